/* File: core/dds_cw1_regs.svh */
// Constants for the first control word register bank
// Contract
// - Serial register addresses 0x00 through 0x16 are decoded, twenty-three in all.
// - Addresses 0x05 and 0x06 are unused; twenty-one registers remain.
// - First control word sits at address 0x00 and is four bytes long.
// - Bit zero is the LSB; range A:B runs from A down to B.
// - Written bits wait in a buffer until update strobe or profile change.
// - Bit 31 enables RAM functions; default zero.
// - Bits 30:29 select RAM playback destination; default 00.
// - Bit 23 enables the external shift-keying pin, only while bits 9:8 equal 10.
// - Bit 22 inserts the inverse sinc filter; default bypassed.
// - Bits 20:17 internal profile act at once, only while bit 31 set.
// - Bit 16 selects sine output; clear selects cosine.
// - Bit 15 reloads ramp rate timer on update, needs second word bit 19.
// - Bit 14 clears the ramp accumulator for one cycle per update.
// - Ramp accumulator clear aligns to update then the next sync clock edge.
// - Bit 13 clears the phase accumulator synchronously on each update.
`ifndef DDS_CW1_REGS_SVH
`define DDS_CW1_REGS_SVH
`define ADDR_CW1 5'h00
`define ADDR_LAST 5'h16
`define ADDR_UNUSED_A 5'h05
`define ADDR_UNUSED_B 5'h06
`define INSTR_LAST 5'h07
`define DATA_LAST 5'h1F
`define INSTR_RD_BIT 7
`define CW1_MASK 32'hE0DFE000
`define CW1_RESET 32'h00000000
`define BIT_RAM_EN 31
`define BIT_DEST_HI 30
`define BIT_DEST_LO 29
`define BIT_OSK_EXT 23
`define BIT_INV_SINC 22
`define BIT_PROF_HI 20
`define BIT_PROF_LO 17
`define BIT_SINE 16
`define BIT_RAMP_RELOAD 15
`define BIT_RAMP_CLR 14
`define BIT_PHASE_CLR 13
`define OSK_MANUAL 2'h2
`define PROF_NONE 4'h0
`endif

/* File: core/dds_cw1_pkg.sv */
// Types shared by the control word bank and its serial port
package dds_cw1_pkg;
  typedef struct packed {
    logic rd;
    logic [4:0] addr;
  } instr_t;
  typedef struct packed {
    logic stb;
    logic [31:0] data;
  } wr_t;
  typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_SKIP} port_state_t;
endpackage

/* File: core/cw1_serial_port.sv */
// Serial configuration port: pin synchronisers, instruction and data shifting
`timescale 1ns/1ps
`default_nettype none
`include "dds_cw1_regs.svh"
module cw1_serial_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  input wire logic [31:0] rd_data,
  output dds_cw1_pkg::instr_t instr_q,
  output logic instr_stb_q,
  output dds_cw1_pkg::wr_t wr_q,
  output logic sdo_q,
  output logic sdo_oe_q
);
  logic [2:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] sdio_s_q;
  logic [31:0] shift_q;
  logic [31:0] out_q;
  logic [4:0] cnt_q;
  dds_cw1_pkg::port_state_t st_q;
  wire rise_w = sclk_s_q[1] & ~sclk_s_q[2];
  wire fall_w = ~sclk_s_q[1] & sclk_s_q[2];
  wire active_w = ~cs_s_q[1];
  wire [31:0] word_w = {shift_q[30:0], sdio_s_q[1]};
  wire instr_end_w = rise_w && st_q == dds_cw1_pkg::ST_INSTR && cnt_q == `INSTR_LAST;
  wire data_end_w = rise_w && st_q == dds_cw1_pkg::ST_DATA && cnt_q == `DATA_LAST;
  wire is_cw1_w = word_w[4:0] == `ADDR_CW1;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s_q <= 3'h0;
      cs_s_q <= 2'h3;
      sdio_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q <= {cs_s_q[0], cs_n};
      sdio_s_q <= {sdio_s_q[0], sdio_in};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= dds_cw1_pkg::ST_INSTR;
      cnt_q <= 5'h00;
      shift_q <= 32'h00000000;
    end else if (!active_w) begin
      st_q <= dds_cw1_pkg::ST_INSTR;
      cnt_q <= 5'h00;
    end else if (rise_w) begin
      shift_q <= word_w;
      cnt_q <= (instr_end_w || data_end_w) ? 5'h00 : cnt_q + 5'h01;
      if (instr_end_w) begin
        st_q <= is_cw1_w ? dds_cw1_pkg::ST_DATA : dds_cw1_pkg::ST_SKIP;
      end else if (data_end_w) begin
        st_q <= dds_cw1_pkg::ST_SKIP;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instr_q <= '0;
      instr_stb_q <= 1'b0;
      wr_q <= '0;
    end else begin
      instr_stb_q <= instr_end_w && active_w;
      wr_q.stb <= data_end_w && active_w && !instr_q.rd;
      if (instr_end_w) begin
        instr_q <= {word_w[`INSTR_RD_BIT], word_w[4:0]};
      end
      if (data_end_w) begin
        wr_q.data <= word_w;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 32'h00000000;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else if (!active_w) begin
      sdo_oe_q <= 1'b0;
    end else if (instr_end_w) begin
      out_q <= is_cw1_w ? rd_data : 32'h00000000;
    end else if (fall_w && st_q == dds_cw1_pkg::ST_DATA && instr_q.rd) begin
      sdo_q <= out_q[31];
      out_q <= {out_q[30:0], 1'b0};
      sdo_oe_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: core/dds_cw1_bank.sv */
// First control word register bank: buffer, update transfer and strobes
`timescale 1ns/1ps
`default_nettype none
`include "dds_cw1_regs.svh"
module dds_cw1_bank (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdo,
  output logic sdo_oe,
  input wire logic io_update,
  input wire logic [2:0] profile_pins,
  input wire logic [1:0] osk_sel,
  input wire logic ramp_gen_en,
  output logic ram_enable_q,
  output logic [1:0] ram_dest_q,
  output logic osk_ext_en_q,
  output logic inv_sinc_en_q,
  output logic [3:0] profile_int_q,
  output logic sine_sel_q,
  output logic ramp_reload_q,
  output logic ramp_clear_q,
  output logic phase_clear_q,
  output logic bad_addr_q
);
  dds_cw1_pkg::instr_t instr;
  dds_cw1_pkg::wr_t wr;
  logic instr_stb;
  logic [31:0] buf_q;
  logic [31:0] active_q;
  logic [1:0] upd_s_q;
  logic upd_prev_q;
  logic [2:0] prof_s1_q;
  logic [2:0] prof_s2_q;
  logic [2:0] prof_prev_q;
  logic upd_dly_q;
  logic ramp_arm_q;

  cw1_serial_port port_i (
    .clk(clk),
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdio_in(sdio_in),
    .rd_data(buf_q),
    .instr_q(instr),
    .instr_stb_q(instr_stb),
    .wr_q(wr),
    .sdo_q(sdo),
    .sdo_oe_q(sdo_oe)
  );

  wire addr_range_w = instr.addr <= `ADDR_LAST;
  wire addr_unused_w = instr.addr == `ADDR_UNUSED_A || instr.addr == `ADDR_UNUSED_B;
  wire bad_addr_d = instr_stb && (!addr_range_w || addr_unused_w);
  wire io_rise_w = upd_s_q[1] & ~upd_prev_q;
  wire pin_change_w = prof_s2_q != prof_prev_q;
  wire [3:0] profile_int_d = buf_q[`BIT_RAM_EN] ? buf_q[`BIT_PROF_HI:`BIT_PROF_LO] : `PROF_NONE;
  wire int_change_w = profile_int_d != profile_int_q;
  wire upd_w = io_rise_w | pin_change_w | int_change_w;
  wire osk_ext_d = active_q[`BIT_OSK_EXT] && osk_sel == `OSK_MANUAL;
  wire reload_d = upd_w && buf_q[`BIT_RAMP_RELOAD] && ramp_gen_en;
  wire phase_clr_d = upd_w && buf_q[`BIT_PHASE_CLR];
  wire ramp_arm_d = upd_w && buf_q[`BIT_RAMP_CLR];

  assign ram_enable_q = active_q[`BIT_RAM_EN];
  assign ram_dest_q = active_q[`BIT_DEST_HI:`BIT_DEST_LO];
  assign inv_sinc_en_q = active_q[`BIT_INV_SINC];
  assign sine_sel_q = active_q[`BIT_SINE];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_s_q <= 2'h0;
      upd_prev_q <= 1'b0;
      prof_s1_q <= 3'h0;
      prof_s2_q <= 3'h0;
      prof_prev_q <= 3'h0;
    end else begin
      upd_s_q <= {upd_s_q[0], io_update};
      upd_prev_q <= upd_s_q[1];
      prof_s1_q <= profile_pins;
      prof_s2_q <= prof_s1_q;
      prof_prev_q <= prof_s2_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buf_q <= `CW1_RESET;
    end else if (wr.stb) begin
      buf_q <= wr.data & `CW1_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      active_q <= `CW1_RESET;
    end else if (upd_w) begin
      active_q <= buf_q;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      profile_int_q <= `PROF_NONE;
      osk_ext_en_q <= 1'b0;
      ramp_reload_q <= 1'b0;
      phase_clear_q <= 1'b0;
      ramp_arm_q <= 1'b0;
      ramp_clear_q <= 1'b0;
      upd_dly_q <= 1'b0;
      bad_addr_q <= 1'b0;
    end else begin
      profile_int_q <= profile_int_d;
      osk_ext_en_q <= osk_ext_d;
      ramp_reload_q <= reload_d;
      phase_clear_q <= phase_clr_d;
      ramp_arm_q <= ramp_arm_d;
      ramp_clear_q <= ramp_arm_q;
      upd_dly_q <= upd_w;
      bad_addr_q <= bad_addr_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  buffer_hold_a: assert property (!upd_w |=> $stable(active_q))
    else $error("active word changed without update");
  update_copy_a: assert property (upd_w |=> active_q == $past(buf_q))
    else $error("active word not loaded from buffer");
  reserved_zero_a: assert property ((buf_q & ~`CW1_MASK) == 32'h00000000)
    else $error("unimplemented bits hold a value");
  write_land_a: assert property (wr.stb |=> buf_q == ($past(wr.data) & `CW1_MASK))
    else $error("written word not captured");
  phase_clear_a: assert property (##1 phase_clear_q == $past(upd_w && buf_q[`BIT_PHASE_CLR]))
    else $error("phase clear does not follow update");
  ramp_clear_a: assert property (upd_w && buf_q[`BIT_RAMP_CLR] |-> ##2 ramp_clear_q)
    else $error("ramp clear missing two cycles after update");
  ramp_once_a: assert property (ramp_clear_q |-> $past(upd_w, 2))
    else $error("ramp clear without its update");
  timer_reload_a: assert property (ramp_reload_q |-> $past(upd_w && ramp_gen_en))
    else $error("ramp timer reload without cause");
  osk_gate_a: assert property (osk_ext_en_q |-> $past(osk_sel) == `OSK_MANUAL)
    else $error("shift keying pin enabled outside manual mode");
  profile_gate_a: assert property (!buf_q[`BIT_RAM_EN] |=> profile_int_q == `PROF_NONE)
    else $error("internal profile active without RAM enable");
  bad_addr_a: assert property (instr_stb && instr.addr > `ADDR_LAST |=> bad_addr_q)
    else $error("out of range address not flagged");
  unused_addr_a: assert property (instr_stb && instr.addr == `ADDR_UNUSED_A |=> bad_addr_q)
    else $error("unused address not flagged");
  unused_b_a: assert property (instr_stb && instr.addr == `ADDR_UNUSED_B |=> bad_addr_q)
    else $error("second unused address not flagged");
  good_addr_a: assert property (instr_stb && addr_range_w && !addr_unused_w |=> !bad_addr_q)
    else $error("implemented address flagged");
  profile_follow_a: assert property (buf_q[`BIT_RAM_EN] |=>
    profile_int_q == $past(buf_q[`BIT_PROF_HI:`BIT_PROF_LO]))
    else $error("internal profile does not follow buffer");
  ramp_bit_a: assert property (ramp_clear_q |-> $past(buf_q[`BIT_RAMP_CLR], 2))
    else $error("ramp clear without its enable bit");
  reload_bit_a: assert property (ramp_reload_q |-> $past(buf_q[`BIT_RAMP_RELOAD]))
    else $error("ramp timer reload without its enable bit");
  osk_bit_a: assert property (osk_ext_en_q |-> $past(active_q[`BIT_OSK_EXT]))
    else $error("shift keying pin enabled without its bit");
  osk_on_a: assert property (active_q[`BIT_OSK_EXT] && osk_sel == `OSK_MANUAL |=> osk_ext_en_q)
    else $error("shift keying pin not enabled in manual mode");
  write_kind_a: assert property (wr.stb |-> !instr.rd)
    else $error("read frame wrote the buffer");
  read_drive_a: assert property (sdo_oe |-> instr.rd && instr.addr == `ADDR_CW1)
    else $error("read line driven outside a control word read");
  buffer_keep_a: assert property (!wr.stb |=> $stable(buf_q))
    else $error("buffer changed without a write");

  write_seen_c: cover property (wr.stb ##[1:40] io_rise_w);
  phase_clr_c: cover property (phase_clear_q);
  ramp_clr_c: cover property (ramp_clear_q);
  profile_chg_c: cover property (pin_change_w && upd_dly_q == 1'b0);
  read_seen_c: cover property (instr_stb && instr.rd);
endmodule
`default_nettype wire

/* File: test/serial_host.sv */
// Host model driving the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input wire logic clk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdio_in,
  output logic [31:0] rd_q
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_in = 1'b0;
    rd_q = 32'h0;
  end
  // Data set in the low phase, taken by the device on the rising edge
  task automatic put_bit(input logic b);
    sclk <= 1'b0;
    sdio_in <= b;
    repeat (5) @(posedge clk);
    rd_q <= {rd_q[30:0], sdo};
    sclk <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  // Instruction byte then n data bits, MSB first; clock idles low
  task automatic frame(input logic [7:0] ins, input logic [31:0] d, input int n);
    cs_n <= 1'b0;
    repeat (5) @(posedge clk);
    for (int i = 7; i >= 0; i--) put_bit(ins[i]);
    for (int i = 31; i > 31 - n; i--) put_bit(d[i]);
    sclk <= 1'b0;
    sdio_in <= ~sdio_in;
    repeat (5) @(posedge clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: test/dds_cw1_bank_tb.sv */
// Testbench for the first control word register bank
`timescale 1ns/1ps
`default_nettype none
module dds_cw1_bank_tb;
  logic clk, resetn, sclk, cs_n, sdio_in, sdo, sdo_oe, io_update, ramp_gen_en;
  logic ram_enable_q, osk_ext_en_q, inv_sinc_en_q, sine_sel_q, ramp_reload_q;
  logic ramp_clear_q, phase_clear_q, bad_addr_q;
  logic [2:0] profile_pins;
  logic [1:0] osk_sel, ram_dest_q;
  logic [3:0] profile_int_q;
  logic [31:0] w, a, rd;
  logic [7:0] bad_list [4] = '{8'h05, 8'h06, 8'h17, 8'h16};
  int mismatches = 0, checked = 0, cyc = 0, n_ph, n_rc, n_rr, n_bad, n_oe, t_ph, t_rc;
  wire logic [5:0] act_obs = {ram_enable_q, ram_dest_q, osk_ext_en_q, inv_sinc_en_q, sine_sel_q};
  dds_cw1_bank uut (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdo(sdo), .sdo_oe(sdo_oe), .io_update(io_update), .profile_pins(profile_pins),
    .osk_sel(osk_sel), .ramp_gen_en(ramp_gen_en), .ram_enable_q(ram_enable_q),
    .ram_dest_q(ram_dest_q), .osk_ext_en_q(osk_ext_en_q), .inv_sinc_en_q(inv_sinc_en_q),
    .profile_int_q(profile_int_q), .sine_sel_q(sine_sel_q), .ramp_reload_q(ramp_reload_q),
    .ramp_clear_q(ramp_clear_q), .phase_clear_q(phase_clear_q), .bad_addr_q(bad_addr_q));
  // Released read line shows the inverse of the last bit
  serial_host host (.clk(clk), .sdo(sdo_oe ? sdo : ~sdo), .sclk(sclk), .cs_n(cs_n),
    .sdio_in(sdio_in),
    .rd_q(rd));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (phase_clear_q === 1'b1) begin
      n_ph <= n_ph + 1;
      t_ph <= cyc;
    end
    if (ramp_clear_q === 1'b1) begin
      n_rc <= n_rc + 1;
      t_rc <= cyc;
    end
    if (ramp_reload_q === 1'b1) n_rr <= n_rr + 1;
    if (bad_addr_q === 1'b1) n_bad <= n_bad + 1;
    if (sdo_oe === 1'b1) n_oe <= n_oe + 1;
  end
  function automatic logic [5:0] act(input logic [31:0] v, input logic [1:0] os);
    return {v[31], v[30:29], v[23] && os == 2'h2, v[22], v[16]};
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [31:0] v);
    host.frame(8'h80, 32'hAAAAAAAA, 32);
    cmp(rd, v & 32'hE0DFE000, "readback");
    cmp(32'(sdo_oe), 32'h0, "drive off");
  endtask
  // Update pulse, then check the transfer and the one-cycle strobes
  task automatic upd(input logic [31:0] v, input logic en);
    @(posedge clk);
    n_ph = 0;
    n_rc = 0;
    n_rr = 0;
    io_update <= 1'b1;
    ramp_gen_en <= en;
    repeat (4) @(posedge clk);
    io_update <= 1'b0;
    repeat (8) @(posedge clk);
    cmp(32'(act_obs), 32'(act(v, osk_sel)), "active");
    cmp(32'(n_ph), 32'(v[13]), "phase clear");
    cmp(32'(n_rc), 32'(v[14]), "ramp clear");
    cmp(32'(n_rr), 32'(v[15] & en), "ramp reload");
    if (v[13] & v[14]) cmp(32'(t_rc - t_ph), 32'h1, "clear align");
  endtask
  initial begin
    #300us;
    mismatches++;
    end_sim();
  end
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    io_update = 1'b0;
    ramp_gen_en = 1'b0;
    profile_pins = 3'h0;
    osk_sel = 2'h0;
    a = 32'h0;
    void'($urandom(65836));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(32'(act_obs), 32'h0, "reset");
    rd_chk(32'h0);
    for (int k = 0; k < 6; k++) begin
      w = (k == 2 || k == 3) ? 32'h7FFFFFFF : ($urandom() & 32'h7FFFFFFF);
      osk_sel <= 2'(k);
      host.frame(8'h00, w, 32);
      cmp(32'(act_obs), 32'(act(a, osk_sel)), "held");
      rd_chk(w);
      upd(w, k[0]);
      a = w;
    end
    host.frame(8'h00, 32'hFFFFFFFF, 20);
    rd_chk(a);
    host.frame(8'h00, 32'h801E0000, 32);
    repeat (4) @(posedge clk);
    cmp(32'(profile_int_q), 32'hF, "profile on");
    cmp(32'(act_obs), 32'(act(32'h801E0000, osk_sel)), "profile move");
    host.frame(8'h00, 32'h001E0000, 32);
    repeat (4) @(posedge clk);
    cmp(32'(profile_int_q), 32'h0, "profile off");
    a = $urandom() & 32'h7FFFFFFF;
    host.frame(8'h00, a, 32);
    profile_pins <= 3'h5;
    repeat (8) @(posedge clk);
    cmp(32'(act_obs), 32'(act(a, osk_sel)), "pin profile");
    foreach (bad_list[i]) begin
      n_bad = 0;
      n_oe = 0;
      host.frame(bad_list[i], $urandom(), 32);
      cmp(32'(n_bad), 32'(bad_list[i] != 8'h16), "bad address");
      cmp(32'(n_oe), 32'h0, "no drive");
      rd_chk(a);
    end
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(32'({act_obs, profile_int_q}), 32'h0, "reset again");
    rd_chk(32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
